// file: core/urs_consts.svh
// register offsets, field positions and key values of the channel register select
`ifndef URS_CONSTS_SVH
`define URS_CONSTS_SVH

`define URS_ADDR_HOLD 3'h0
`define URS_ADDR_INT_EN 3'h1
`define URS_ADDR_INT_SRC 3'h2
`define URS_ADDR_LINE_CTRL 3'h3
`define URS_ADDR_MODEM_CTRL 3'h4
`define URS_ADDR_LINE_STAT 3'h5
`define URS_ADDR_MODEM_STAT 3'h6
`define URS_ADDR_SCRATCH 3'h7

`define URS_ENH_KEY 8'hbf
`define URS_DIV_ZERO 8'h00
`define URS_LINE_CTRL_DIV_BIT 7
`define URS_ENH_FUNC_EXT_BIT 4
`define URS_FEAT_SWAP_BIT 6
`define URS_FEAT_DIR_BIT 7

`define URS_INT_EN_EXT_MASK 8'hf0
`define URS_INT_SRC_EXT_MASK 8'h30
`define URS_FIFO_CTRL_EXT_MASK 8'h30
`define URS_MODEM_CTRL_EXT_MASK 8'he0

`define URS_RST_BYTE 8'h00
`define URS_RST_LINE_CTRL 8'h00
`define URS_RST_MODEM_CTRL 8'h00
`define URS_RST_INT_EN 8'h00
`define URS_RST_ENH_FUNC 8'h00
`define URS_RST_FEAT 8'h00

`endif

// file: core/urs_pkg.sv
// types shared by the channel register select
`default_nettype none
package urs_pkg;

    // writable configuration as seen by the serial engine
    typedef struct packed {
        logic [7:0] line_control;
        logic [7:0] baud_divisor_low;
        logic [7:0] baud_divisor_high;
        logic [7:0] interrupt_enable;
        logic [7:0] modem_control;
        logic [7:0] feature_control;
        logic [7:0] enhanced_function;
        logic [7:0] resume_char_1;
        logic [7:0] resume_char_2;
        logic [7:0] pause_char_1;
        logic [7:0] pause_char_2;
    } urs_cfg_t;

    // status returned by the serial engine
    typedef struct packed {
        logic [7:0] rx_holding;
        logic [7:0] interrupt_source;
        logic [7:0] line_status;
        logic [7:0] modem_status;
        logic [7:0] rx_fifo_level;
        logic [7:0] tx_fifo_level;
    } urs_stat_t;

    // one-cycle strobes towards the serial engine
    typedef struct packed {
        logic tx_load;
        logic rx_pop;
        logic src_read;
        logic line_stat_read;
        logic modem_stat_read;
        logic fifo_ctrl_write;
        logic trigger_write;
        logic mode_sel_write;
    } urs_strobe_t;

    typedef struct packed {
        urs_cfg_t cfg;
        logic [7:0] scratchpad;
        logic [7:0] wdata;
        logic [7:0] rdata;
        urs_strobe_t strobe;
    } urs_state_t;

endpackage
`default_nettype wire

// file: core/urs_regsel.sv
// register select and register bank for one channel of the dual uart
`include "urs_consts.svh"
`default_nettype none
module urs_regsel #(
    parameter bit CHANNEL_B = 1'b0,
    parameter logic [7:0] REVISION_CODE = 8'h01, // arbitrary value
    parameter logic [7:0] DEVICE_IDENT = 8'h5c // arbitrary value
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic chan_a_select_n_in,
    input wire logic chan_b_select_n_in,
    input wire logic [2:0] addr_in,
    input wire logic rd_in,
    input wire logic wr_in,
    input wire logic [7:0] wdata_in,
    input wire urs_pkg::urs_stat_t stat_in,
    output logic [7:0] rdata_out,
    output logic [7:0] wdata_out,
    output urs_pkg::urs_cfg_t cfg_out,
    output urs_pkg::urs_strobe_t strobe_out
);

    // ****************************************
    // access decode
    // ****************************************
    urs_pkg::urs_state_t state_reg;
    urs_pkg::urs_state_t state_next;
    logic sel;
    logic key_mode;
    logic div_mode;
    logic div_zero;
    logic ext_on;
    logic swap;
    logic rd_acc;
    logic wr_acc;
    logic [7:0] fifo_level;

    // only this channel's select opens the bank; the other channel is a twin instance
    assign sel = CHANNEL_B ? !chan_b_select_n_in : !chan_a_select_n_in;
    assign rd_acc = sel && rd_in && !wr_in;
    assign wr_acc = sel && wr_in && !rd_in;
    assign key_mode = state_reg.cfg.line_control == `URS_ENH_KEY;
    assign div_mode = state_reg.cfg.line_control[`URS_LINE_CTRL_DIV_BIT] && !key_mode;
    assign div_zero = state_reg.cfg.baud_divisor_low == `URS_DIV_ZERO &&
        state_reg.cfg.baud_divisor_high == `URS_DIV_ZERO;
    assign ext_on = state_reg.cfg.enhanced_function[`URS_ENH_FUNC_EXT_BIT];
    assign swap = state_reg.cfg.feature_control[`URS_FEAT_SWAP_BIT];
    // direction bit picks which fifo the level counters report
    assign fifo_level = state_reg.cfg.feature_control[`URS_FEAT_DIR_BIT] ? stat_in.rx_fifo_level :
        stat_in.tx_fifo_level;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        state_next = state_reg;
        state_next.strobe = '0;
        if (wr_acc) begin
            state_next.wdata = wdata_in;
            unique case (addr_in)
                `URS_ADDR_HOLD: begin
                    if (key_mode) begin
                        state_next.strobe.trigger_write = 1'b1;
                    end else if (div_mode) begin
                        state_next.cfg.baud_divisor_low = wdata_in;
                    end else begin
                        state_next.strobe.tx_load = 1'b1;
                    end
                end
                `URS_ADDR_INT_EN: begin
                    if (key_mode) begin
                        state_next.cfg.feature_control = wdata_in;
                    end else if (div_mode) begin
                        state_next.cfg.baud_divisor_high = wdata_in;
                    end else begin
                        // extended bits keep their value while locked
                        state_next.cfg.interrupt_enable = ext_on ? wdata_in :
                            (wdata_in & ~`URS_INT_EN_EXT_MASK) |
                            (state_reg.cfg.interrupt_enable & `URS_INT_EN_EXT_MASK);
                    end
                end
                `URS_ADDR_INT_SRC: begin
                    if (key_mode) begin
                        state_next.cfg.enhanced_function = wdata_in;
                    end else begin
                        state_next.strobe.fifo_ctrl_write = 1'b1;
                        state_next.wdata = ext_on ? wdata_in : wdata_in & ~`URS_FIFO_CTRL_EXT_MASK;
                    end
                end
                `URS_ADDR_LINE_CTRL: begin
                    state_next.cfg.line_control = wdata_in;
                end
                `URS_ADDR_MODEM_CTRL: begin
                    if (key_mode) begin
                        state_next.cfg.resume_char_1 = wdata_in;
                    end else begin
                        state_next.cfg.modem_control = ext_on ? wdata_in :
                            (wdata_in & ~`URS_MODEM_CTRL_EXT_MASK) |
                            (state_reg.cfg.modem_control & `URS_MODEM_CTRL_EXT_MASK);
                    end
                end
                `URS_ADDR_LINE_STAT: begin
                    // reserved outside the key, so only the write data register takes the byte
                    if (key_mode) begin
                        state_next.cfg.resume_char_2 = wdata_in;
                    end
                end
                `URS_ADDR_MODEM_STAT: begin
                    if (key_mode) begin
                        state_next.cfg.pause_char_1 = wdata_in;
                    end
                end
                `URS_ADDR_SCRATCH: begin
                    if (key_mode) begin
                        state_next.cfg.pause_char_2 = wdata_in;
                    end else if (swap) begin
                        state_next.strobe.mode_sel_write = 1'b1;
                    end else begin
                        state_next.scratchpad = wdata_in;
                    end
                end
            endcase
        end
        if (rd_acc) begin
            unique case (addr_in)
                `URS_ADDR_HOLD: begin
                    if (key_mode) begin
                        state_next.rdata = fifo_level;
                    end else if (div_mode) begin
                        state_next.rdata = div_zero ? REVISION_CODE : state_reg.cfg.baud_divisor_low;
                    end else begin
                        state_next.rdata = stat_in.rx_holding;
                        state_next.strobe.rx_pop = 1'b1;
                    end
                end
                `URS_ADDR_INT_EN: begin
                    if (key_mode) begin
                        state_next.rdata = state_reg.cfg.feature_control;
                    end else if (div_mode) begin
                        state_next.rdata = div_zero ? DEVICE_IDENT : state_reg.cfg.baud_divisor_high;
                    end else begin
                        state_next.rdata = ext_on ? state_reg.cfg.interrupt_enable :
                            state_reg.cfg.interrupt_enable & ~`URS_INT_EN_EXT_MASK;
                    end
                end
                `URS_ADDR_INT_SRC: begin
                    if (key_mode) begin
                        state_next.rdata = state_reg.cfg.enhanced_function;
                    end else begin
                        state_next.rdata = ext_on ? stat_in.interrupt_source :
                            stat_in.interrupt_source & ~`URS_INT_SRC_EXT_MASK;
                        state_next.strobe.src_read = 1'b1;
                    end
                end
                `URS_ADDR_LINE_CTRL: begin
                    state_next.rdata = state_reg.cfg.line_control;
                end
                `URS_ADDR_MODEM_CTRL: begin
                    if (key_mode) begin
                        state_next.rdata = state_reg.cfg.resume_char_1;
                    end else begin
                        state_next.rdata = ext_on ? state_reg.cfg.modem_control :
                            state_reg.cfg.modem_control & ~`URS_MODEM_CTRL_EXT_MASK;
                    end
                end
                `URS_ADDR_LINE_STAT: begin
                    if (key_mode) begin
                        state_next.rdata = state_reg.cfg.resume_char_2;
                    end else begin
                        state_next.rdata = stat_in.line_status;
                        state_next.strobe.line_stat_read = 1'b1;
                    end
                end
                `URS_ADDR_MODEM_STAT: begin
                    if (key_mode) begin
                        state_next.rdata = state_reg.cfg.pause_char_1;
                    end else begin
                        state_next.rdata = stat_in.modem_status;
                        state_next.strobe.modem_stat_read = 1'b1;
                    end
                end
                `URS_ADDR_SCRATCH: begin
                    if (key_mode) begin
                        state_next.rdata = state_reg.cfg.pause_char_2;
                    end else begin
                        state_next.rdata = swap ? fifo_level : state_reg.scratchpad;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_reg <= '0;
            state_reg.cfg.line_control <= `URS_RST_LINE_CTRL;
            state_reg.cfg.modem_control <= `URS_RST_MODEM_CTRL;
            state_reg.cfg.interrupt_enable <= `URS_RST_INT_EN;
            state_reg.cfg.enhanced_function <= `URS_RST_ENH_FUNC;
            state_reg.cfg.feature_control <= `URS_RST_FEAT;
            state_reg.rdata <= `URS_RST_BYTE;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rdata_out = state_reg.rdata;
    assign wdata_out = state_reg.wdata;
    assign cfg_out = state_reg.cfg;
    assign strobe_out = state_reg.strobe;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    property p_unselected;
        !sel |=> strobe_out == '0 && $stable(cfg_out) && $stable(rdata_out);
    endproperty
    a_unselected: assert property (p_unselected) else $error("bank changed while unselected");

    // a second load right behind the first may keep the strobe up legally
    property p_tx_load;
        wr_acc && addr_in == `URS_ADDR_HOLD && !state_reg.cfg.line_control[`URS_LINE_CTRL_DIV_BIT]
        |=> strobe_out.tx_load && wdata_out == $past(wdata_in) ##1 (!strobe_out.tx_load || $past(wr_acc));
    endproperty
    a_tx_load: assert property (p_tx_load) else $error("transmit load missing");

    property p_tx_only;
        strobe_out.tx_load |-> $past(wr_acc && addr_in == `URS_ADDR_HOLD && !div_mode && !key_mode);
    endproperty
    a_tx_only: assert property (p_tx_only) else $error("transmit load without request");

    property p_rx_pop;
        rd_acc && addr_in == `URS_ADDR_HOLD && !state_reg.cfg.line_control[`URS_LINE_CTRL_DIV_BIT]
        |=> strobe_out.rx_pop && rdata_out == $past(stat_in.rx_holding);
    endproperty
    a_rx_pop: assert property (p_rx_pop) else $error("receive read wrong");

    property p_div_low;
        wr_acc && addr_in == `URS_ADDR_HOLD && div_mode
        |=> cfg_out.baud_divisor_low == $past(wdata_in) && !strobe_out.tx_load;
    endproperty
    a_div_low: assert property (p_div_low) else $error("divisor low not stored");

    property p_div_high;
        wr_acc && addr_in == `URS_ADDR_INT_EN && div_mode |=> cfg_out.baud_divisor_high == $past(wdata_in);
    endproperty
    a_div_high: assert property (p_div_high) else $error("divisor high not stored");

    property p_ident;
        rd_acc && addr_in == `URS_ADDR_INT_EN && div_mode && div_zero |=> rdata_out == DEVICE_IDENT;
    endproperty
    a_ident: assert property (p_ident) else $error("ident not returned");

    property p_revision;
        rd_acc && addr_in == `URS_ADDR_HOLD && div_mode && div_zero |=> rdata_out == REVISION_CODE;
    endproperty
    a_revision: assert property (p_revision) else $error("revision not returned");

    property p_int_en_read;
        rd_acc && addr_in == `URS_ADDR_INT_EN && !state_reg.cfg.line_control[`URS_LINE_CTRL_DIV_BIT]
        |=> rdata_out[3:0] == $past(cfg_out.interrupt_enable[3:0]);
    endproperty
    a_int_en_read: assert property (p_int_en_read) else $error("interrupt enable read wrong");

    property p_int_en_write;
        wr_acc && addr_in == `URS_ADDR_INT_EN && !state_reg.cfg.line_control[`URS_LINE_CTRL_DIV_BIT]
        |=> cfg_out.interrupt_enable[3:0] == $past(wdata_in[3:0]);
    endproperty
    a_int_en_write: assert property (p_int_en_write) else $error("interrupt enable not stored");

    property p_src_read;
        rd_acc && addr_in == `URS_ADDR_INT_SRC && !key_mode
        |=> strobe_out.src_read && rdata_out[3:0] == $past(stat_in.interrupt_source[3:0]);
    endproperty
    a_src_read: assert property (p_src_read) else $error("status read wrong");

    property p_fifo_ctrl_write;
        wr_acc && addr_in == `URS_ADDR_INT_SRC && !key_mode
        |=> strobe_out.fifo_ctrl_write && wdata_out[3:0] == $past(wdata_in[3:0]);
    endproperty
    a_fifo_ctrl_write: assert property (p_fifo_ctrl_write) else $error("fifo control write missing");

    property p_line_ctrl_write;
        wr_acc && addr_in == `URS_ADDR_LINE_CTRL |=> cfg_out.line_control == $past(wdata_in);
    endproperty
    a_line_ctrl_write: assert property (p_line_ctrl_write) else $error("line control not stored");

    property p_modem_write;
        wr_acc && addr_in == `URS_ADDR_MODEM_CTRL && !key_mode
        |=> cfg_out.modem_control[4:0] == $past(wdata_in[4:0]);
    endproperty
    a_modem_write: assert property (p_modem_write) else $error("modem control not stored");

    property p_reserved_write;
        wr_acc && !key_mode && (addr_in == `URS_ADDR_LINE_STAT || addr_in == `URS_ADDR_MODEM_STAT)
        |=> $stable(cfg_out) && strobe_out == '0;
    endproperty
    a_reserved_write: assert property (p_reserved_write) else $error("reserved write changed state");

    property p_line_stat_read;
        rd_acc && addr_in == `URS_ADDR_LINE_STAT && !key_mode
        |=> strobe_out.line_stat_read && rdata_out == $past(stat_in.line_status);
    endproperty
    a_line_stat_read: assert property (p_line_stat_read) else $error("line status read wrong");

    // the host leaves one idle cycle between accesses
    property p_scratch;
        wr_acc && addr_in == `URS_ADDR_SCRATCH && !key_mode && !swap ##1 !wr_acc ##1
        rd_acc && addr_in == `URS_ADDR_SCRATCH && !key_mode && !swap |=> rdata_out == $past(wdata_in, 3);
    endproperty
    a_scratch: assert property (p_scratch) else $error("scratchpad mismatch");

    property p_mode_sel_write;
        wr_acc && addr_in == `URS_ADDR_SCRATCH && !key_mode && swap
        |=> strobe_out.mode_sel_write && wdata_out == $past(wdata_in);
    endproperty
    a_mode_sel_write: assert property (p_mode_sel_write) else $error("mode select write missing");

    property p_level_read;
        rd_acc && addr_in == `URS_ADDR_HOLD && key_mode |=> rdata_out == $past(fifo_level);
    endproperty
    a_level_read: assert property (p_level_read) else $error("level count wrong");

    property p_trigger_write;
        wr_acc && addr_in == `URS_ADDR_HOLD && key_mode |=> strobe_out.trigger_write && !strobe_out.tx_load;
    endproperty
    a_trigger_write: assert property (p_trigger_write) else $error("trigger write missing");

    property p_enh_func_write;
        wr_acc && addr_in == `URS_ADDR_INT_SRC && key_mode
        |=> cfg_out.enhanced_function == $past(wdata_in) && !strobe_out.fifo_ctrl_write;
    endproperty
    a_enh_func_write: assert property (p_enh_func_write) else $error("enhanced function not stored");

    property p_feature_write;
        wr_acc && addr_in == `URS_ADDR_INT_EN && key_mode |=> cfg_out.feature_control == $past(wdata_in);
    endproperty
    a_feature_write: assert property (p_feature_write) else $error("feature control not stored");

    property p_pause2;
        wr_acc && addr_in == `URS_ADDR_SCRATCH && key_mode
        |=> cfg_out.pause_char_2 == $past(wdata_in) && !strobe_out.mode_sel_write;
    endproperty
    a_pause2: assert property (p_pause2) else $error("pause char 2 not stored");

    property p_resume1;
        wr_acc && addr_in == `URS_ADDR_MODEM_CTRL && key_mode |=> cfg_out.resume_char_1 == $past(wdata_in);
    endproperty
    a_resume1: assert property (p_resume1) else $error("resume char 1 not stored");

    property p_ext_locked;
        rd_acc && addr_in == `URS_ADDR_INT_EN && !key_mode && !state_reg.cfg.line_control[`URS_LINE_CTRL_DIV_BIT]
        && !ext_on |=> rdata_out[7:4] == 4'h0;
    endproperty
    a_ext_locked: assert property (p_ext_locked) else $error("extended bits visible");

    property p_ext_kept;
        wr_acc && addr_in == `URS_ADDR_INT_EN && !state_reg.cfg.line_control[`URS_LINE_CTRL_DIV_BIT] && !ext_on
        |=> cfg_out.interrupt_enable[7:4] == $past(cfg_out.interrupt_enable[7:4]);
    endproperty
    a_ext_kept: assert property (p_ext_kept) else $error("locked bits changed");

    c_key_mode: cover property (wr_acc && addr_in == `URS_ADDR_LINE_CTRL && wdata_in == `URS_ENH_KEY);
    c_ident: cover property (rd_acc && addr_in == `URS_ADDR_INT_EN && div_mode && div_zero);
    c_swap: cover property (wr_acc && addr_in == `URS_ADDR_SCRATCH && !key_mode && swap);
    c_tx: cover property (strobe_out.tx_load);

endmodule
`default_nettype wire

// file: testbench/urs_host_model.sv
// host processor model for the channel register bus
`default_nettype none
module urs_host_model (
    input wire logic clk_in,
    input wire logic [7:0] rdata_in,
    output logic chan_a_select_n_out,
    output logic chan_b_select_n_out,
    output logic [2:0] addr_out,
    output logic rd_out,
    output logic wr_out,
    output logic [7:0] wdata_out
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        chan_a_select_n_out = 1'b1;
        chan_b_select_n_out = 1'b1;
        addr_out = 3'h0;
        rd_out = 1'b0;
        wr_out = 1'b0;
        wdata_out = 8'h00;
    end

    // ****************************************
    // one access, taken at the edge after setup
    // ****************************************
    task automatic access(input logic use_b, input logic is_wr, input logic [2:0] a,
                          input logic [7:0] d, output logic [7:0] q);
        @(posedge clk_in);
        chan_a_select_n_out <= use_b;
        chan_b_select_n_out <= ~use_b;
        addr_out <= a;
        rd_out <= ~is_wr;
        wr_out <= is_wr;
        wdata_out <= d;
        @(posedge clk_in);
        chan_a_select_n_out <= 1'b1;
        chan_b_select_n_out <= 1'b1;
        rd_out <= 1'b0;
        wr_out <= 1'b0;
        // released bus shows inverted values so stale data never passes for valid
        addr_out <= ~a;
        wdata_out <= ~d;
        @(negedge clk_in);
        q = rdata_in;
    endtask
endmodule
`default_nettype wire

// file: testbench/uart_channel_register_select_tb_top.sv
// self-checking bench for the channel register select
`default_nettype none
module uart_channel_register_select_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0] REV = 8'h3e; // arbitrary value
    localparam logic [7:0] DID = 8'h7b; // arbitrary value
    localparam logic [7:0] S_NO = 8'h00;
    localparam logic [7:0] S_TX = 8'h80;
    localparam logic [7:0] S_RX = 8'h40;
    localparam logic [7:0] S_SRC = 8'h20;
    localparam logic [7:0] S_LST = 8'h10;
    localparam logic [7:0] S_MST = 8'h08;
    localparam logic [7:0] S_FCTL = 8'h04;
    localparam logic [7:0] S_TRIG = 8'h02;
    localparam logic [7:0] S_EMS = 8'h01;

    logic clk_in;
    logic rst_in;
    logic cs_a_n;
    logic cs_b_n;
    logic [2:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
    urs_pkg::urs_stat_t stat;
    logic [7:0] rdata_out;
    logic [7:0] wdata_out;
    urs_pkg::urs_cfg_t cfg_out;
    urs_pkg::urs_strobe_t strobe_out;
    urs_pkg::urs_cfg_t snap;
    logic [7:0] q;
    int fails;
    int tests_run;

    urs_regsel #(.CHANNEL_B(1'b0), .REVISION_CODE(REV), .DEVICE_IDENT(DID)) i_dut (
        .clk_in(clk_in), .rst_in(rst_in), .chan_a_select_n_in(cs_a_n), .chan_b_select_n_in(cs_b_n),
        .addr_in(addr), .rd_in(rd), .wr_in(wr), .wdata_in(wdata), .stat_in(stat),
        .rdata_out(rdata_out), .wdata_out(wdata_out), .cfg_out(cfg_out), .strobe_out(strobe_out));

    urs_host_model i_host (
        .clk_in(clk_in), .rdata_in(rdata_out), .chan_a_select_n_out(cs_a_n),
        .chan_b_select_n_out(cs_b_n), .addr_out(addr), .rd_out(rd), .wr_out(wr), .wdata_out(wdata));

    initial clk_in = 1'b0;
    always #4 clk_in = ~clk_in;

    // ****************************************
    // checks and bus helpers
    // ****************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cfg_same(input urs_pkg::urs_cfg_t s);
        for (int i = 0; i < 11; i++) begin
            chk(cfg_out[i*8 +: 8], s[i*8 +: 8]);
        end
    endtask

    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d, input logic [7:0] es);
        logic [7:0] r;
        i_host.access(1'b0, 1'b1, a, d, r);
        chk(strobe_out, es);
    endtask

    task automatic rd_reg(input logic [2:0] a, input logic [7:0] exp, input logic [7:0] es);
        logic [7:0] r;
        i_host.access(1'b0, 1'b0, a, 8'h00, r);
        chk(r, exp);
        chk(strobe_out, es);
    endtask

    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // generous: the sequence needs under 150 cycles
    initial begin
        #(8 * 5000);
        fails++;
        finish_test();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        fails = 0;
        tests_run = 0;
        rst_in = 1'b1;
        stat = {8'h11, 8'hf3, 8'h55, 8'h66, 8'h21, 8'h12};
        repeat (16) @(posedge clk_in);
        rst_in <= 1'b0;
        @(negedge clk_in);
        cfg_same('0);
        rd_reg(3'h3, 8'h00, S_NO);
        end_test("reset");
        wr_reg(3'h0, 8'ha5, S_TX);
        chk(wdata_out, 8'ha5);
        rd_reg(3'h0, 8'h11, S_RX);
        end_test("holding");
        wr_reg(3'h1, 8'hff, S_NO);
        rd_reg(3'h1, 8'h0f, S_NO);
        rd_reg(3'h2, 8'hc3, S_SRC);
        wr_reg(3'h2, 8'hff, S_FCTL);
        chk(wdata_out, 8'hcf);
        wr_reg(3'h4, 8'hff, S_NO);
        rd_reg(3'h4, 8'h1f, S_NO);
        snap = cfg_out;
        wr_reg(3'h5, 8'h77, S_NO);
        wr_reg(3'h6, 8'h77, S_NO);
        cfg_same(snap);
        rd_reg(3'h5, 8'h55, S_LST);
        rd_reg(3'h6, 8'h66, S_MST);
        wr_reg(3'h7, 8'h3c, S_NO);
        rd_reg(3'h7, 8'h3c, S_NO);
        end_test("plain");
        wr_reg(3'h3, 8'h80, S_NO);
        rd_reg(3'h0, REV, S_NO);
        rd_reg(3'h1, DID, S_NO);
        wr_reg(3'h0, 8'h34, S_NO);
        wr_reg(3'h1, 8'h12, S_NO);
        rd_reg(3'h0, 8'h34, S_NO);
        rd_reg(3'h1, 8'h12, S_NO);
        chk(cfg_out.baud_divisor_low, 8'h34);
        end_test("divisor");
        wr_reg(3'h3, 8'hbf, S_NO);
        rd_reg(3'h3, 8'hbf, S_NO);
        wr_reg(3'h1, 8'h40, S_NO);
        wr_reg(3'h2, 8'h10, S_NO);
        rd_reg(3'h1, 8'h40, S_NO);
        rd_reg(3'h2, 8'h10, S_NO);
        for (int i = 4; i < 8; i++) begin
            wr_reg(3'(i), 8'ha0 + 8'(i), S_NO);
        end
        for (int i = 4; i < 8; i++) begin
            rd_reg(3'(i), 8'ha0 + 8'(i), S_NO);
        end
        chk(cfg_out.pause_char_2, 8'ha7);
        rd_reg(3'h0, 8'h12, S_NO);
        wr_reg(3'h0, 8'h08, S_TRIG);
        wr_reg(3'h1, 8'hc0, S_NO);
        rd_reg(3'h0, 8'h21, S_NO);
        end_test("enhanced");
        wr_reg(3'h3, 8'h03, S_NO);
        rd_reg(3'h7, 8'h21, S_NO);
        wr_reg(3'h7, 8'h55, S_EMS);
        wr_reg(3'h1, 8'hff, S_NO);
        rd_reg(3'h1, 8'hff, S_NO);
        wr_reg(3'h4, 8'hff, S_NO);
        rd_reg(3'h4, 8'hff, S_NO);
        rd_reg(3'h2, 8'hf3, S_SRC);
        wr_reg(3'h2, 8'hff, S_FCTL);
        chk(wdata_out, 8'hff);
        end_test("swap");
        rd_reg(3'h3, 8'h03, S_NO);
        i_host.access(1'b1, 1'b1, 3'h3, 8'h00, q);
        chk(strobe_out, S_NO);
        i_host.access(1'b1, 1'b0, 3'h0, 8'h00, q);
        chk(q, 8'h03);
        chk(strobe_out, S_NO);
        rd_reg(3'h3, 8'h03, S_NO);
        end_test("channel");
        finish_test();
    end
endmodule
`default_nettype wire
